//--- verilog/aro_output_port.sv
/*
 * Result output port of a 16-bit converter: parallel bus, serial port
 * with internal or external shift clock, busy, frame marker and
 * incomplete read flag. Assumes the conversion core gives a start pulse
 * and a result pulse with data on clock; all other pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aro_consts.svh"

module aro_output_port (
    input wire logic clock,
    input wire logic rstn,
    input wire logic shiftClockIn,
    input wire logic deviceReset,
    input wire logic startConversion,
    input wire logic resultValid,
    input wire aro_pkg::aro_word_t resultData,
    input wire logic csN,
    input wire logic rdN,
    input wire logic serialParallelSelect,
    input wire logic clockSourceSelect,
    input wire logic frameMarkerPolarity,
    input wire logic shiftClockInvert,
    input wire logic outputCodingSelect,
    output logic [15:0] dataOut,
    output logic [15:0] dataOe,
    output logic conversionBusy
);
    logic [`ARO_NSYNC-1:0] pinRaw;
    logic [`ARO_NSYNC-1:0] syncA_q;
    logic [`ARO_NSYNC-1:0] syncB_q;
    logic [`ARO_NSYNC-1:0] syncC_q;
    logic [`ARO_NSYNC-1:0] pin_q;

    logic devRst;
    logic csLow;
    logic rdLow;
    logic serialMode;
    logic extClock;
    logic frmPol;
    logic sckInv;
    logic straightBinary;
    logic linkBusy;

    logic busEnable;
    logic internalSerial;
    logic externalSerial;

    logic busy_q;
    logic busy_d;
    aro_pkg::aro_word_t word_q;
    aro_pkg::aro_word_t word_d;
    aro_pkg::aro_word_t codedResult;
    logic unread_q;
    logic unread_d;
    logic clearLink_q;
    logic clearLink_d;
    logic [3:0] errCount_q;
    logic [3:0] errCount_d;
    logic incompleteReadFlag;
    logic lostRead;
    logic publish;

    aro_pkg::aro_shift_state_e state_q;
    aro_pkg::aro_shift_state_e state_d;
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic [3:0] bitIdx_q;
    logic [3:0] bitIdx_d;
    logic sdoInt_q;
    logic sdoInt_d;
    logic sclkInt_q;
    logic sclkInt_d;
    logic frame_q;
    logic frame_d;
    logic startShift;
    logic lastStep;

    logic [15:0] out_q;
    logic [15:0] out_d;
    logic [15:0] oe_q;
    logic [15:0] oe_d;
    logic serialDataLink;
    logic linkActiveRaw;

    // pins from outside the clock domain
    assign pinRaw[`ARO_S_DEVRST] = deviceReset;
    assign pinRaw[`ARO_S_CSN] = csN;
    assign pinRaw[`ARO_S_RDN] = rdN;
    assign pinRaw[`ARO_S_SERIAL] = serialParallelSelect;
    assign pinRaw[`ARO_S_EXTCLK] = clockSourceSelect;
    assign pinRaw[`ARO_S_FRMPOL] = frameMarkerPolarity;
    assign pinRaw[`ARO_S_SCKINV] = shiftClockInvert;
    assign pinRaw[`ARO_S_CODING] = outputCodingSelect;
    assign pinRaw[`ARO_S_LINKACT] = linkActiveRaw;

    // idle level of each pin while in reset
    localparam logic [`ARO_NSYNC-1:0] syncInit = `ARO_SYNC_INIT;

    // three stages; a level counts once the last two agree
    genvar gi;
    generate
        for (gi = 0; gi < `ARO_NSYNC; gi = gi + 1) begin : gSync
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    syncA_q[gi] <= syncInit[gi];
                    syncB_q[gi] <= syncInit[gi];
                    syncC_q[gi] <= syncInit[gi];
                    pin_q[gi] <= syncInit[gi];
                end else begin
                    syncA_q[gi] <= pinRaw[gi];
                    syncB_q[gi] <= syncA_q[gi];
                    syncC_q[gi] <= syncB_q[gi];
                    if (syncB_q[gi] == syncC_q[gi]) begin
                        pin_q[gi] <= syncC_q[gi];
                    end
                end
            end
        end
    endgenerate

    assign devRst = pin_q[`ARO_S_DEVRST];
    assign csLow = !pin_q[`ARO_S_CSN];
    assign rdLow = !pin_q[`ARO_S_RDN];
    assign serialMode = pin_q[`ARO_S_SERIAL];
    assign extClock = pin_q[`ARO_S_EXTCLK];
    assign frmPol = pin_q[`ARO_S_FRMPOL];
    assign sckInv = pin_q[`ARO_S_SCKINV];
    assign straightBinary = pin_q[`ARO_S_CODING];
    assign linkBusy = pin_q[`ARO_S_LINKACT];

    assign busEnable = csLow && rdLow;
    assign internalSerial = serialMode && !extClock;
    assign externalSerial = serialMode && extClock;

    // msb inverted for twos complement
    assign codedResult = {resultData[15] ^ !straightBinary, resultData[14:0]};

    // result is latched only outside reset; reset drops any conversion
    assign publish = resultValid && !devRst;
    assign lostRead = publish && externalSerial && linkBusy;

    always_comb begin
        busy_d = busy_q;
        if (devRst) begin
            busy_d = 1'b0;
        end else if (startConversion) begin
            busy_d = 1'b1;
        end else if (resultValid) begin
            busy_d = 1'b0;
        end
    end

    always_comb begin
        word_d = word_q;
        unread_d = unread_q;
        if (devRst) begin
            word_d = `ARO_WORD_RESET;
            unread_d = 1'b0;
        end else if (publish) begin
            word_d = codedResult;
            unread_d = 1'b1;
        end else if (startShift) begin
            unread_d = 1'b0;
        end
    end

    // restart the link shifter on every new result
    assign clearLink_d = publish || devRst;

    always_comb begin
        errCount_d = errCount_q;
        if (devRst) begin
            errCount_d = 4'h0;
        end else if (lostRead) begin
            errCount_d = `ARO_RDERR_LEN;
        end else if (errCount_q != 4'h0) begin
            errCount_d = errCount_q - 4'h1;
        end
    end
    assign incompleteReadFlag = errCount_q != 4'h0;

    // internal shift clock: data changes a quarter period before the rise
    assign startShift = (state_q == aro_pkg::stIdle) && internalSerial && busEnable && unread_q;
    assign lastStep = (phase_q == `ARO_PHASE_LAST) && (bitIdx_q == `ARO_LAST_BIT);

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        bitIdx_d = bitIdx_q;
        case (state_q)
            aro_pkg::stIdle: begin
                phase_d = 2'h0;
                bitIdx_d = 4'h0;
                if (startShift) begin
                    state_d = aro_pkg::stShift;
                end
            end
            aro_pkg::stShift: begin
                phase_d = phase_q + 2'h1;
                if (phase_q == `ARO_PHASE_LAST) begin
                    bitIdx_d = bitIdx_q + 4'h1;
                end
                if (lastStep) begin
                    state_d = aro_pkg::stIdle;
                end
            end
            default: begin
                state_d = aro_pkg::stIdle;
            end
        endcase
        if (devRst) begin
            state_d = aro_pkg::stIdle;
        end
    end

    assign frame_d = state_d == aro_pkg::stShift;
    assign sclkInt_d = frame_d && (phase_d >= `ARO_PHASE_RISE) && (phase_d < `ARO_PHASE_FALL);
    assign sdoInt_d = (frame_d && phase_d == 2'h0) ? word_q[`ARO_LAST_BIT - bitIdx_d] : sdoInt_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            word_q <= `ARO_WORD_RESET;
            unread_q <= 1'b0;
            clearLink_q <= 1'b1;
            errCount_q <= 4'h0;
        end else begin
            busy_q <= busy_d;
            word_q <= word_d;
            unread_q <= unread_d;
            clearLink_q <= clearLink_d;
            errCount_q <= errCount_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q <= aro_pkg::stIdle;
            phase_q <= 2'h0;
            bitIdx_q <= 4'h0;
            sdoInt_q <= 1'b0;
            sclkInt_q <= 1'b0;
            frame_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            bitIdx_q <= bitIdx_d;
            sdoInt_q <= sdoInt_d;
            sclkInt_q <= sclkInt_d;
            frame_q <= frame_d;
        end
    end

    // link-domain shifter for the external clock
    aro_serial_link uLink (
        .linkClock(shiftClockIn),
        .clearLink(clearLink_q),
        .csN(csN),
        .shiftClockInvert(shiftClockInvert),
        .word(word_q),
        .serialDataLink(serialDataLink),
        .linkActive(linkActiveRaw)
    );

    // pin values per mode
    always_comb begin
        out_d = word_q;
        if (serialMode) begin
            out_d = 16'h0000;
            out_d[15:`ARO_TOP_LO] = word_q[15:`ARO_TOP_LO];
            out_d[`ARO_BIT_RDERR] = incompleteReadFlag;
            out_d[`ARO_BIT_FRAME] = frame_q ^ frmPol;
            out_d[`ARO_BIT_SCLK] = sclkInt_q ^ sckInv;
            out_d[`ARO_BIT_SDO] = sdoInt_q;
        end
    end

    // pin enables per mode
    always_comb begin
        oe_d = {16{busEnable}};
        if (serialMode) begin
            oe_d = 16'h0000;
            oe_d[15:`ARO_TOP_LO] = {4{busEnable}};
            oe_d[`ARO_BIT_RDERR] = busEnable && extClock;
            oe_d[`ARO_BIT_FRAME] = busEnable && !extClock;
            oe_d[`ARO_BIT_SCLK] = busEnable && !extClock;
            oe_d[`ARO_BIT_SDO] = busEnable;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            out_q <= 16'h0000;
            oe_q <= 16'h0000;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    // external clock data bypasses the system clock to keep link timing
    assign dataOut = {out_q[15:`ARO_BIT_SDO+1],
        externalSerial ? serialDataLink : out_q[`ARO_BIT_SDO],
        out_q[`ARO_BIT_SDO-1:0]};
    assign dataOe = oe_q;
    assign conversionBusy = busy_q;
endmodule : aro_output_port
`default_nettype wire

//--- include/aro_consts.svh
/*
 * Constants of the converter result output port: pin positions, counts
 * and reset values. Assumes it is included by bare name after the package.
 */
// How it works
// - parallel mode drives shared pins as data bits 8 to 11; flags unavailable.
// - serial mode shifts stored result out MSB first, coded per coding select.
// - internal shift clock keeps each data bit valid across both clock edges.
// - external clock, no inversion: data updates on rising edge, host samples falling.
// - external clock, inverted: data updates on falling edge, host samples rising.
// - shift clock pin is our output when internal, host input when external.
// - internal clock frame marker covers valid data; polarity select flips its level.
// - external read unfinished at next conversion end loses data, pulses error flag.
// - top four data pins stay outputs in both serial and parallel modes.
// - busy rises at conversion start, falls once result is latched for output.
// - output bus enabled only while chip select and read strobe are low.
// - external shift clock edges are ignored while chip select is high.
// - reset input high returns to reset state, aborting any conversion.
// - coding select high gives straight binary; low inverts MSB for twos complement.
// - serial/parallel select low uses parallel port, high uses serial port.
// - clock source select low drives own shift clock, high follows external clock.
`ifndef ARO_CONSTS_SVH
`define ARO_CONSTS_SVH

`define ARO_WIDTH 16
`define ARO_BIT_SDO 8
`define ARO_BIT_SCLK 9
`define ARO_BIT_FRAME 10
`define ARO_BIT_RDERR 11
`define ARO_TOP_LO 12
`define ARO_BIT_COUNT 5'h10
`define ARO_LAST_BIT 4'hF
`define ARO_PHASE_LAST 2'h3
`define ARO_PHASE_RISE 2'h1
`define ARO_PHASE_FALL 2'h3
`define ARO_RDERR_LEN 4'h8
`define ARO_WORD_RESET 16'h0000
`define ARO_NSYNC 9
`define ARO_SYNC_INIT 9'h006
`define ARO_S_DEVRST 0
`define ARO_S_CSN 1
`define ARO_S_RDN 2
`define ARO_S_SERIAL 3
`define ARO_S_EXTCLK 4
`define ARO_S_FRMPOL 5
`define ARO_S_SCKINV 6
`define ARO_S_CODING 7
`define ARO_S_LINKACT 8

`endif

//--- include/aro_pkg.sv
/*
 * Types of the converter result output port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package aro_pkg;
    typedef logic [15:0] aro_word_t;
    typedef logic [4:0] aro_index_t;
    typedef enum logic [1:0] {
        stIdle,
        stShift
    } aro_shift_state_e;
endpackage : aro_pkg

//--- verilog/aro_serial_link.sv
/*
 * Link-side shifter clocked by the host's shift clock.
 * Assumes the word is held still while a frame runs and that
 * clearLink is a registered pulse from the system domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aro_consts.svh"

module aro_serial_link (
    input wire logic linkClock,
    input wire logic clearLink,
    input wire logic csN,
    input wire logic shiftClockInvert,
    input wire aro_pkg::aro_word_t word,
    output logic serialDataLink,
    output logic linkActive
);
    aro_pkg::aro_index_t idxRise_q;
    aro_pkg::aro_index_t idxFall_q;
    logic sdoRise_q;
    logic sdoFall_q;
    logic activeRise_q;
    logic activeFall_q;
    logic riseMore;
    logic fallMore;

    function automatic logic pickBit(input aro_pkg::aro_word_t w, input aro_pkg::aro_index_t i);
        pickBit = w[`ARO_LAST_BIT - i[3:0]];
    endfunction : pickBit

    // chip select gates the clock, and a frame stops after sixteen bits
    assign riseMore = !csN && (idxRise_q != `ARO_BIT_COUNT);
    assign fallMore = !csN && (idxFall_q != `ARO_BIT_COUNT);

    always_ff @(posedge linkClock or posedge clearLink) begin
        if (clearLink) begin
            idxRise_q <= 5'h00;
            sdoRise_q <= 1'b0;
            activeRise_q <= 1'b0;
        end else if (riseMore) begin
            sdoRise_q <= pickBit(word, idxRise_q);
            idxRise_q <= idxRise_q + 5'h01;
            activeRise_q <= idxRise_q[3:0] != `ARO_LAST_BIT;
        end
    end

    always_ff @(negedge linkClock or posedge clearLink) begin
        if (clearLink) begin
            idxFall_q <= 5'h00;
            sdoFall_q <= 1'b0;
            activeFall_q <= 1'b0;
        end else if (fallMore) begin
            sdoFall_q <= pickBit(word, idxFall_q);
            idxFall_q <= idxFall_q + 5'h01;
            activeFall_q <= idxFall_q[3:0] != `ARO_LAST_BIT;
        end
    end

    assign serialDataLink = shiftClockInvert ? sdoFall_q : sdoRise_q;
    // from flops only, so the crossing never sees counter glitches
    assign linkActive = shiftClockInvert ? activeFall_q : activeRise_q;
endmodule : aro_serial_link
`default_nettype wire

//--- sim/aro_port_assertions.sv
/* pin assertions for the result output port
   assumes binding into aro_output_port */
`timescale 1ns/1ps
`default_nettype none
module aro_port_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire logic deviceReset,
    input wire logic startConversion,
    input wire logic resultValid,
    input wire logic csN,
    input wire logic rdN,
    input wire logic serialParallelSelect,
    input wire logic [15:0] dataOe,
    input wire logic conversionBusy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_cs_high_off: assert property (csN [*6] |-> dataOe == 16'h0000)
        else $error("bus driven with chip select high");
    a_rd_high_off: assert property (rdN [*6] |-> dataOe == 16'h0000)
        else $error("bus driven with read strobe high");
    a_par_bus_on: assert property ((!csN && !rdN && !serialParallelSelect) [*6]
        |-> dataOe == 16'hFFFF)
        else $error("parallel bus not fully driven");
    a_ser_pin_map: assert property ((!csN && !rdN && serialParallelSelect) [*6]
        |-> dataOe[15:12] == 4'hF && dataOe[7:0] == 8'h00)
        else $error("serial pin map wrong");
    a_busy_rise: assert property (startConversion && !deviceReset |=> conversionBusy)
        else $error("busy missing after start");
    a_busy_fall: assert property (resultValid && conversionBusy |=> !conversionBusy)
        else $error("busy not cleared by result");
    a_busy_hold: assert property ((!deviceReset) [*6] ##0 (conversionBusy && !resultValid)
        |=> conversionBusy)
        else $error("busy dropped early");
    a_reset_abort: assert property (deviceReset [*6] |-> !conversionBusy)
        else $error("busy survives device reset");
endmodule : aro_port_checker
bind aro_output_port aro_port_checker u_chk (.clock(clock), .rstn(rstn),
    .deviceReset(deviceReset), .startConversion(startConversion),
    .resultValid(resultValid), .csN(csN), .rdN(rdN),
    .serialParallelSelect(serialParallelSelect), .dataOe(dataOe),
    .conversionBusy(conversionBusy));
`default_nettype wire

//--- sim/aro_host_model.sv
/* host model: runs the external shift clock in bursts
   assumes the clock stands at its idle level between bursts */
`timescale 1ns/1ps
`default_nettype none
module aro_host_model (
    input wire logic go,
    input wire logic invert,
    input wire logic [4:0] edges,
    input wire logic serialData,
    output logic shiftClock,
    output logic active,
    output logic [15:0] rxWord
);
    logic phase;
    assign shiftClock = invert ^ phase;
    initial begin
        phase = 1'b0;
        active = 1'b0;
        rxWord = 16'h0000;
    end
    always @(posedge go) begin
        active = 1'b1;
        #3;
        repeat (edges) begin
            #40 phase = 1'b1;
            #40 phase = 1'b0;
            rxWord = {rxWord[14:0], serialData};
        end
        active = 1'b0;
    end
endmodule : aro_host_model
`default_nettype wire

//--- sim/testbench.sv
/* self-checking bench of the result output port
   assumes the host model drives the external shift clock */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic devRst = 1'b0, start = 1'b0, valid = 1'b0, go = 1'b0;
    logic csN = 1'b1, rdN = 1'b1, serSel = 1'b0, extSel = 1'b0;
    logic pol = 1'b0, inv = 1'b0, coding = 1'b1, sclkIn, active, prevSclk;
    logic [4:0] edges = 5'h00;
    logic [15:0] data = 16'h0000, dataOut, dataOe, rxWord, got, first;
    logic busy, sdoSeen;
    logic [15:0] errCycles = 16'h0000;
    int failures = 0, cmp_count = 0, n;
    always #2.5 clock = ~clock;
    always @(posedge clock) if (dataOut[11] && dataOe[11] && extSel) errCycles++;
    aro_output_port u_dut (.clock(clock), .rstn(rstn), .shiftClockIn(sclkIn),
        .deviceReset(devRst), .startConversion(start), .resultValid(valid),
        .resultData(data), .csN(csN), .rdN(rdN), .serialParallelSelect(serSel),
        .clockSourceSelect(extSel), .frameMarkerPolarity(pol),
        .shiftClockInvert(inv), .outputCodingSelect(coding), .dataOut(dataOut),
        .dataOe(dataOe), .conversionBusy(busy));
    // released data pin reads as the inverse of its last level
    assign sdoSeen = dataOe[8] ? dataOut[8] : !dataOut[8];
    aro_host_model u_host (.go(go), .invert(inv), .edges(edges),
        .serialData(sdoSeen), .shiftClock(sclkIn), .active(active), .rxWord(rxWord));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask : tick
    task automatic bus(input logic c, input logic r);
        csN <= c;
        rdN <= r;
        tick(8);
    endtask : bus
    task automatic convert(input logic [15:0] w);
        start <= 1'b1;
        tick(1);
        start <= 1'b0;
        tick(3);
        check("busy", busy, 1'b1);
        valid <= 1'b1;
        data <= w;
        tick(1);
        valid <= 1'b0;
        tick(2);
        check("busy", busy, 1'b0);
    endtask : convert
    task automatic burst(input logic [4:0] k);
        edges <= k;
        go <= 1'b1;
        tick(2);
        go <= 1'b0;
        for (int j = 0; j < 400 && active; j++) tick(1);
        check("burst end", active, 1'b0);
    endtask : burst
    task automatic summarize;
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        #300000;
        failures++;
        summarize();
    end
    initial begin
        tick(3);
        rstn <= 1'b1;
        tick(6);
        check("oe", dataOe, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            coding <= i[0];
            tick(6);
            convert(16'hA5C3);
            bus(1'b0, 1'b0);
            check("oe", dataOe, 16'hFFFF);
            check("par", dataOut, 16'hA5C3 ^ {~i[0], 15'h0000});
            bus(1'b1, 1'b0);
            check("oe", dataOe, 16'h0000);
            bus(1'b0, 1'b1);
            check("oe", dataOe, 16'h0000);
            bus(1'b1, 1'b1);
        end
        serSel <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            pol <= p[0];
            tick(6);
            convert(16'h9C35);
            csN <= 1'b0;
            rdN <= 1'b0;
            n = 0;
            prevSclk = 1'b0;
            for (int k = 0; k < 300 && n < 16; k++) begin
                tick(1);
                if (dataOut[9] && !prevSclk) begin
                    got = {got[14:0], dataOut[8]};
                    n++;
                    check("mark", dataOut[10], !p[0]);
                end
                if (!dataOut[9] && prevSclk) check("hold", dataOut[8], got[0]);
                prevSclk = dataOut[9];
            end
            check("ser", got, 16'h9C35);
            check("sclk oe", dataOe[9], 1'b1);
            tick(10);
            check("mark end", dataOut[10], p[0]);
            bus(1'b1, 1'b1);
        end
        extSel <= 1'b1;
        errCycles = 16'h0000;
        for (int v = 0; v < 2; v++) begin
            inv <= v[0];
            tick(6);
            convert(16'h5A3C);
            bus(1'b0, 1'b0);
            burst(5'h10);
            check("ext", rxWord, 16'h5A3C);
            check("sclk oe", dataOe[9], 1'b0);
            bus(1'b1, 1'b1);
        end
        convert(16'hE718);
        bus(1'b0, 1'b0);
        burst(5'h08);
        first = rxWord;
        bus(1'b1, 1'b0);
        burst(5'h04);
        bus(1'b0, 1'b0);
        burst(5'h08);
        check("gated", {first[7:0], rxWord[7:0]}, 16'hE718);
        check("err", errCycles, 16'h0000);
        convert(16'h1234);
        burst(5'h04);
        convert(16'h0F0F);
        tick(20);
        check("err", errCycles, 16'h0008);
        burst(5'h10);
        check("ext", rxWord, 16'h0F0F);
        bus(1'b1, 1'b1);
        start <= 1'b1;
        tick(1);
        start <= 1'b0;
        tick(2);
        devRst <= 1'b1;
        tick(8);
        check("busy", busy, 1'b0);
        devRst <= 1'b0;
        serSel <= 1'b0;
        tick(8);
        bus(1'b0, 1'b0);
        check("par", dataOut, 16'h0000);
        summarize();
    end
endmodule : testbench
`default_nettype wire
